// [hdl/mrps_timer.sv]
`default_nettype none
// Delay timer, restarts whenever run drops
module mrps_timer #(
    parameter int CYCLES = mrps_pkg::MEM_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    mrps_tmr_if.timer tmr
);
    import mrps_pkg::*;
    ////////////////////////////////////////////////////////////
    logic [TMR_W-1:0] cnt_reg; // Elapsed cycles
    logic [TMR_W-1:0] cnt_next;
    logic done_reg; // Delay reached
    logic done_next;
    wire logic at_end = (cnt_reg == TMR_W'(CYCLES - 1));
    ////////////////////////////////////////////////////////////
    // Next count
    assign cnt_next = !tmr.run ? '0 : (done_reg ? cnt_reg : cnt_reg + 1'b1);
    assign done_next = tmr.run && (done_reg || at_end);
    // Counter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end
    assign tmr.done = done_reg;
endmodule
`default_nettype wire

// [hdl/mrps_top.sv]
`default_nettype none
// Rail sequencer with register port
module mrps_top #(
    parameter int MEM_DELAY = mrps_pkg::MEM_DELAY_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Register port
    input wire logic [mrps_pkg::ADDR_W-1:0] ADDR,
    input wire logic [mrps_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [mrps_pkg::DATA_W-1:0] RDATA,
    // Control pins
    input wire logic [mrps_pkg::NUM_CTL-1:0] CTL_IN,
    // Power-good from each rail
    input wire logic [mrps_pkg::NUM_RAILS-1:0] RAIL_PG_IN,
    // Rail enables and discharge
    output logic [mrps_pkg::NUM_RAILS-1:0] RAIL_EN,
    output logic [mrps_pkg::NUM_RAILS-1:0] DISCH_ON,
    output logic [mrps_pkg::NUM_RAILS*mrps_pkg::DISCH_W-1:0] DISCH_SEL,
    // Voltage targets and termination current limit
    output logic [mrps_pkg::MV_W-1:0] BUCK_TWO_MV,
    output logic [mrps_pkg::MV_W-1:0] BUCK_THREE_MV,
    output logic [mrps_pkg::MV_W-1:0] BUCK_SIX_MV,
    output logic [mrps_pkg::MV_W-1:0] TERM_ILIM,
    // General outputs
    output logic GP_OUTPUT_ONE,
    output logic GP_OUTPUT_TWO_O,
    output logic GP_OUTPUT_TWO_OE,
    output logic GP_OUTPUT_THREE_O,
    output logic GP_OUTPUT_THREE_OE,
    output logic GP_OUTPUT_FOUR_O,
    output logic GP_OUTPUT_FOUR_OE,
    output logic FAULT
);
    import mrps_pkg::*;

    ////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [NUM_CTL-1:0] ctl_meta_reg; // First stage only
    logic [NUM_CTL-1:0] ctl_reg; // Safe control levels
    logic [NUM_RAILS-1:0] pg_meta_reg; // First stage only
    logic [NUM_RAILS-1:0] pg_reg; // Safe power-good levels

    // Two flops per pin
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctl_meta_reg <= '0;
            ctl_reg <= '0;
            pg_meta_reg <= '0;
            pg_reg <= '0;
        end else begin
            ctl_meta_reg <= CTL_IN;
            ctl_reg <= ctl_meta_reg;
            pg_meta_reg <= RAIL_PG_IN;
            pg_reg <= pg_meta_reg;
        end
    end

    // Named pin levels
    wire logic memory_seq_enable_in = ctl_reg[CTL_MEM_SEQ];
    wire logic memory_voltage_select_in = ctl_reg[CTL_MEM_VSEL];
    wire logic termination_enable_in = ctl_reg[CTL_TERM_EN];
    wire logic core_rail_good_in = ctl_reg[CTL_CORE_GOOD];
    wire logic termination_seq_enable_in = ctl_reg[CTL_TERM_SEQ];
    wire logic sleep_control_in = ctl_reg[CTL_SLEEP];

    ////////////////////////////////////////////////////////////
    // Software registers
    logic [1:0] rail_ctrl_reg; // Linear regs two, three
    logic [2:0] shared_ctrl_reg; // Switch two enable, discharge
    logic [15:0] disch_one_reg; // Discharge, rails 0..7
    logic [5:0] disch_two_reg; // Discharge, rails 8..10
    logic [MV_W-1:0] b3_volt_reg; // Buck three normal voltage
    logic [MV_W-1:0] b3_sleep_reg; // Buck three sleep voltage
    logic gpo_two_reg; // Output two level
    logic [NUM_RAILS-1:0] fault_reg; // Sticky rail faults
    logic [NUM_RAILS-1:0] fault_next;
    logic [DATA_W-1:0] rdata_reg; // Read data
    logic [DATA_W-1:0] rdata_next;

    // Address decode
    wire logic wr_rail = WR && (ADDR == OFS_RAIL_CTRL);
    wire logic wr_shared = WR && (ADDR == OFS_SHARED_CTRL);
    wire logic wr_disch_one = WR && (ADDR == OFS_DISCH_ONE);
    wire logic wr_disch_two = WR && (ADDR == OFS_DISCH_TWO);
    wire logic wr_b3 = WR && (ADDR == OFS_B3_VOLT);
    wire logic wr_b3_sleep = WR && (ADDR == OFS_B3_SLEEP_VOLT);
    wire logic wr_fault = WR && (ADDR == OFS_FAULT);
    wire logic wr_gpo = WR && (ADDR == OFS_GPO_CTRL);

    // Control register writes
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rail_ctrl_reg <= RST_RAIL_CTRL;
            shared_ctrl_reg <= RST_SHARED_CTRL;
            gpo_two_reg <= RST_GPO_TWO;
        end else begin
            // Linear regs two, three only from here
            if (wr_rail) begin
                rail_ctrl_reg <= WDATA[1:0];
            end
            // Shared register steers switch two
            if (wr_shared) begin
                shared_ctrl_reg <= WDATA[2:0];
            end
            if (wr_gpo) begin
                gpo_two_reg <= WDATA[BIT_GPO_TWO];
            end
        end
    end

    // Discharge strength registers
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            disch_one_reg <= RST_DISCH_ONE;
            disch_two_reg <= RST_DISCH_TWO;
        end else begin
            if (wr_disch_one) begin
                disch_one_reg <= WDATA[15:0];
            end
            if (wr_disch_two) begin
                disch_two_reg <= WDATA[5:0];
            end
        end
    end

    // Buck three voltage registers, defaults fixed
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            b3_volt_reg <= B3_NORMAL_MV;
            b3_sleep_reg <= B3_SLEEP_MV;
        end else begin
            if (wr_b3) begin
                b3_volt_reg <= WDATA[MV_W-1:0];
            end
            // Path used while sleep pin is low
            if (wr_b3_sleep) begin
                b3_sleep_reg <= WDATA[MV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Main power-up chain
    mrps_seq_t seq_reg; // Chain state
    mrps_seq_t seq_next;

    // Next chain step, each waits for previous power-good
    always_comb begin
        seq_next = seq_reg;
        if (!termination_enable_in) begin
            // Pin low drops the whole chain
            seq_next = SEQ_OFF;
        end else begin
            case (seq_reg)
                SEQ_OFF: seq_next = SEQ_B1;
                SEQ_B1: begin
                    if (pg_reg[RAIL_BUCK1]) begin
                        seq_next = SEQ_B34;
                    end
                end
                SEQ_B34: begin
                    if (pg_reg[RAIL_BUCK_THREE] && pg_reg[RAIL_BUCK4]) begin
                        seq_next = SEQ_CORE;
                    end
                end
                // Core rail slot: output one out, input four back
                SEQ_CORE: begin
                    if (core_rail_good_in) begin
                        seq_next = SEQ_B2;
                    end
                end
                SEQ_B2: begin
                    if (pg_reg[RAIL_BUCK_TWO]) begin
                        seq_next = SEQ_B5;
                    end
                end
                SEQ_B5: begin
                    if (pg_reg[RAIL_BUCK_FIVE]) begin
                        seq_next = SEQ_ON;
                    end
                end
                SEQ_ON: seq_next = SEQ_ON;
                default: seq_next = SEQ_OFF;
            endcase
        end
    end

    // Chain state
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            seq_reg <= SEQ_OFF;
        end else begin
            seq_reg <= seq_next;
        end
    end

    ////////////////////////////////////////////////////////////
    // Memory branch timer
    mrps_tmr_if tmr_bus ();

    // Count from buck five enable while memory sequence is asked
    assign tmr_bus.run = memory_seq_enable_in && RAIL_EN[RAIL_BUCK_FIVE];

    mrps_timer #(
        .CYCLES(MEM_DELAY)
    ) u_mem_timer (
        .clk(SYS_CLK),
        .nrst(NRST),
        .tmr(tmr_bus.timer)
    );

    ////////////////////////////////////////////////////////////
    // Enable decode
    wire logic past_b1 = (seq_reg != SEQ_OFF);
    wire logic past_b34 = past_b1 && (seq_reg != SEQ_B1);
    wire logic past_core = past_b34 && (seq_reg != SEQ_B34);
    wire logic past_b2 = past_core && (seq_reg != SEQ_CORE);
    wire logic past_b5 = past_b2 && (seq_reg != SEQ_B2);
    wire logic chain_on = (seq_reg == SEQ_ON);
    wire logic b6_good = pg_reg[RAIL_BUCK_SIX];
    wire logic b6_en = tmr_bus.done;
    wire logic lin_one_en = memory_seq_enable_in && RAIL_EN[RAIL_BUCK_SIX] && b6_good;
    wire logic term_en = termination_seq_enable_in && RAIL_EN[RAIL_BUCK_SIX] && b6_good;
    wire logic sw_two_en = chain_on && shared_ctrl_reg[BIT_SW_TWO_EN];
    logic [NUM_RAILS-1:0] en_next;

    // Gather enables per rail
    always_comb begin
        en_next = '0;
        en_next[RAIL_BUCK1] = past_b1;
        en_next[RAIL_BUCK_THREE] = past_b34;
        en_next[RAIL_BUCK4] = past_b34;
        en_next[RAIL_BUCK_TWO] = past_b2;
        en_next[RAIL_BUCK_FIVE] = past_b5;
        en_next[RAIL_BUCK_SIX] = b6_en && past_b5;
        en_next[RAIL_LIN_ONE] = lin_one_en && past_b5;
        en_next[RAIL_LIN_TWO] = rail_ctrl_reg[BIT_LIN_TWO_EN];
        en_next[RAIL_LIN_THREE] = rail_ctrl_reg[BIT_LIN_THREE_EN];
        en_next[RAIL_TERM] = term_en && termination_enable_in;
        en_next[RAIL_SW_ONE] = chain_on;
        en_next[RAIL_SW_TWO] = sw_two_en;
    end

    ////////////////////////////////////////////////////////////
    // Voltage selection
    wire logic b2_sleep = B2_SLEEP_EN && !sleep_control_in;
    wire logic b3_sleep = B3_SLEEP_EN && !sleep_control_in;
    wire logic b6_sleep = B6_SLEEP_EN && !sleep_control_in;
    wire logic [MV_W-1:0] b2_mv = b2_sleep ? B2_SLEEP_MV : B2_NORMAL_MV;
    wire logic [MV_W-1:0] b3_mv = b3_sleep ? b3_sleep_reg : b3_volt_reg;
    wire logic [MV_W-1:0] b6_pin_mv = memory_voltage_select_in ? B6_HIGH_MV : B6_LOW_MV;
    wire logic [MV_W-1:0] b6_mv = b6_sleep ? B6_SLEEP_MV : b6_pin_mv;

    ////////////////////////////////////////////////////////////
    // Discharge strength per rail
    wire logic [NUM_RAILS*DISCH_W-1:0] disch_sel_next =
        {shared_ctrl_reg[POS_SW_TWO_DISCH +: DISCH_W], disch_two_reg, disch_one_reg};

    ////////////////////////////////////////////////////////////
    // Rail outputs
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            RAIL_EN <= '0;
            DISCH_ON <= '1;
            DISCH_SEL <= '0;
        end else begin
            RAIL_EN <= en_next;
            // Resistor off exactly while rail is enabled
            DISCH_ON <= ~en_next;
            DISCH_SEL <= disch_sel_next;
        end
    end

    // Voltage outputs
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            BUCK_TWO_MV <= B2_NORMAL_MV;
            BUCK_THREE_MV <= B3_NORMAL_MV;
            BUCK_SIX_MV <= B6_LOW_MV;
            TERM_ILIM <= TERM_ILIM_MA;
        end else begin
            BUCK_TWO_MV <= b2_mv;
            BUCK_THREE_MV <= b3_mv;
            BUCK_SIX_MV <= b6_mv;
            TERM_ILIM <= TERM_ILIM_MA;
        end
    end

    ////////////////////////////////////////////////////////////
    // General outputs
    wire logic gpo_one_next = past_core;
    wire logic gpo_three_pg = pg_reg[GPO_THREE_SRC] && RAIL_EN[GPO_THREE_SRC];
    wire logic gpo_four_pg = pg_reg[GPO_FOUR_SRC] && RAIL_EN[GPO_FOUR_SRC];

    // Push-pull one, open-drain others pull low only
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            GP_OUTPUT_ONE <= 1'b0;
            GP_OUTPUT_TWO_O <= 1'b0;
            GP_OUTPUT_TWO_OE <= 1'b1;
            GP_OUTPUT_THREE_O <= 1'b0;
            GP_OUTPUT_THREE_OE <= 1'b1;
            GP_OUTPUT_FOUR_O <= 1'b0;
            GP_OUTPUT_FOUR_OE <= 1'b1;
        end else begin
            GP_OUTPUT_ONE <= gpo_one_next;
            GP_OUTPUT_TWO_O <= 1'b0;
            GP_OUTPUT_TWO_OE <= !gpo_two_reg;
            GP_OUTPUT_THREE_O <= 1'b0;
            GP_OUTPUT_THREE_OE <= !gpo_three_pg;
            GP_OUTPUT_FOUR_O <= 1'b0;
            GP_OUTPUT_FOUR_OE <= !gpo_four_pg;
        end
    end

    ////////////////////////////////////////////////////////////
    // Fault capture
    logic [NUM_RAILS-1:0] was_good_reg; // Rail reached good
    wire logic [NUM_RAILS-1:0] good_next = RAIL_EN & (was_good_reg | pg_reg);
    wire logic [NUM_RAILS-1:0] pg_lost = RAIL_EN & was_good_reg & ~pg_reg & ~FAULT_MASK;
    wire logic [NUM_RAILS-1:0] fault_clr = wr_fault ? WDATA[NUM_RAILS-1:0] : '0;

    // Write one clears, a new loss wins
    assign fault_next = (fault_reg & ~fault_clr) | pg_lost;

    // Fault flags
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            was_good_reg <= '0;
            fault_reg <= '0;
            FAULT <= 1'b0;
        end else begin
            was_good_reg <= good_next;
            fault_reg <= fault_next;
            FAULT <= |fault_next;
        end
    end

    ////////////////////////////////////////////////////////////
    // Read mux, unmapped reads zero
    always_comb begin
        rdata_next = '0;
        case (ADDR)
            OFS_RAIL_CTRL: rdata_next[1:0] = rail_ctrl_reg;
            OFS_SHARED_CTRL: rdata_next[2:0] = shared_ctrl_reg;
            OFS_DISCH_ONE: rdata_next[15:0] = disch_one_reg;
            OFS_DISCH_TWO: rdata_next[5:0] = disch_two_reg;
            OFS_B3_VOLT: rdata_next[MV_W-1:0] = b3_volt_reg;
            OFS_B3_SLEEP_VOLT: rdata_next[MV_W-1:0] = b3_sleep_reg;
            OFS_STATUS: begin
                rdata_next[NUM_RAILS-1:0] = RAIL_EN;
                rdata_next[POS_PG_STATUS +: NUM_RAILS] = pg_reg;
            end
            OFS_FAULT: rdata_next[NUM_RAILS-1:0] = fault_reg;
            OFS_GPO_CTRL: rdata_next[BIT_GPO_TWO] = gpo_two_reg;
            default: rdata_next = '0;
        endcase
    end

    // Read data one cycle after strobe only
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= RD ? rdata_next : '0;
        end
    end
    assign RDATA = rdata_reg;
endmodule
`default_nettype wire

// [inc/mrps_pkg.sv]
// Operation
// - Enabled rail drops its discharge resistor automatically
// - Software sets discharge strength per rail
// - Fixed defaults set voltage, order, faults, mapping
// - Enables follow control pins and prior power-good
// - Buck six 2 ms after five, then reg one
// - Termination regulator follows buck six power-good
// - Memory rail 1.2 V low, 1.35 V high
// - Buck two 0.85 V low, 0.9 V high
// - Linear regs two, three only by register
// - Switches unmerged; shared registers act on switch two
// - Buck two defaults, sleep enabled, follows sleep pin
// - Buck six voltage from select pin only, sleep disabled
// - Termination on pin three, 1.8 A, unmasked
// - Output one push-pull, three and four open-drain
`default_nettype none
package mrps_pkg;
    ////////////////////////////////////////////////////////////
    // Bus and sizes
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_RAILS = 12;
    localparam int NUM_CTL = 6;
    localparam int MV_W = 12;
    localparam int DISCH_W = 2;
    ////////////////////////////////////////////////////////////
    // Rail indices
    localparam int RAIL_BUCK1 = 0;
    localparam int RAIL_BUCK_TWO = 1;
    localparam int RAIL_BUCK_THREE = 2;
    localparam int RAIL_BUCK4 = 3;
    localparam int RAIL_BUCK_FIVE = 4;
    localparam int RAIL_BUCK_SIX = 5;
    localparam int RAIL_LIN_ONE = 6;
    localparam int RAIL_LIN_TWO = 7;
    localparam int RAIL_LIN_THREE = 8;
    localparam int RAIL_TERM = 9;
    localparam int RAIL_SW_ONE = 10;
    localparam int RAIL_SW_TWO = 11;
    ////////////////////////////////////////////////////////////
    // Control pin indices
    localparam int CTL_MEM_SEQ = 0;
    localparam int CTL_MEM_VSEL = 1;
    localparam int CTL_TERM_EN = 2;
    localparam int CTL_CORE_GOOD = 3;
    localparam int CTL_TERM_SEQ = 4;
    localparam int CTL_SLEEP = 5;
    ////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_RAIL_CTRL = 8'h00;
    localparam logic [7:0] OFS_SHARED_CTRL = 8'h04;
    localparam logic [7:0] OFS_DISCH_ONE = 8'h08;
    localparam logic [7:0] OFS_DISCH_TWO = 8'h0C;
    localparam logic [7:0] OFS_B3_VOLT = 8'h10;
    localparam logic [7:0] OFS_B3_SLEEP_VOLT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FAULT = 8'h1C;
    localparam logic [7:0] OFS_GPO_CTRL = 8'h20;
    ////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_LIN_TWO_EN = 0;
    localparam int BIT_LIN_THREE_EN = 1;
    localparam int BIT_SW_TWO_EN = 0;
    localparam int POS_SW_TWO_DISCH = 1;
    localparam int POS_PG_STATUS = 16;
    localparam int BIT_GPO_TWO = 0;
    ////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [1:0] RST_RAIL_CTRL = 2'h0;
    localparam logic [2:0] RST_SHARED_CTRL = 3'h3;
    localparam logic [15:0] RST_DISCH_ONE = 16'h5555;
    localparam logic [5:0] RST_DISCH_TWO = 6'h15;
    localparam logic RST_GPO_TWO = 1'b0;
    ////////////////////////////////////////////////////////////
    // Fixed defaults, millivolts; termination limit in milliamps
    localparam logic [MV_W-1:0] B2_NORMAL_MV = 12'd900;
    localparam logic [MV_W-1:0] B2_SLEEP_MV = 12'd850;
    localparam logic [MV_W-1:0] B3_NORMAL_MV = 12'd1200;
    localparam logic [MV_W-1:0] B3_SLEEP_MV = 12'd1200;
    localparam logic [MV_W-1:0] B6_HIGH_MV = 12'd1350;
    localparam logic [MV_W-1:0] B6_LOW_MV = 12'd1200;
    localparam logic [MV_W-1:0] B6_SLEEP_MV = 12'd1350;
    localparam logic B2_SLEEP_EN = 1'b1;
    localparam logic B3_SLEEP_EN = 1'b1;
    localparam logic B6_SLEEP_EN = 1'b0;
    localparam logic [MV_W-1:0] TERM_ILIM_MA = 12'd1800;
    // Rails whose power faults are ignored
    localparam logic [NUM_RAILS-1:0] FAULT_MASK = 12'hD80;
    // Power-good sources for outputs three and four
    localparam int GPO_THREE_SRC = RAIL_BUCK_FIVE;
    localparam int GPO_FOUR_SRC = RAIL_BUCK_SIX;
    ////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int MEM_DELAY_MS = 2;
    localparam int MEM_DELAY_CYCLES = MEM_DELAY_MS * 1000 * CLK_MHZ;
    localparam int TMR_W = 24;
    ////////////////////////////////////////////////////////////
    // Main chain states
    typedef enum logic [2:0] {
        SEQ_OFF, SEQ_B1, SEQ_B34, SEQ_CORE, SEQ_B2, SEQ_B5, SEQ_ON
    } mrps_seq_t;
endpackage
`default_nettype wire

// [inc/mrps_tmr_if.sv]
`default_nettype none
// Delay timer carrier
interface mrps_tmr_if;
    logic run; // Count while high
    logic done; // Delay elapsed
    modport master (output run, input done);
    modport timer (input run, output done);
endinterface
`default_nettype wire

// [sim/mrps_chk.sv]
`default_nettype none
// Port checks of the rail sequencer
module mrps_chk
    import mrps_pkg::*;
#(
    parameter int MEM_DELAY = 20
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [5:0] CTL_IN,
    input wire logic [11:0] RAIL_EN,
    input wire logic [11:0] DISCH_ON,
    input wire logic [11:0] BUCK_TWO_MV,
    input wire logic [11:0] BUCK_SIX_MV,
    input wire logic [11:0] TERM_ILIM,
    input wire logic GP_OUTPUT_TWO_O,
    input wire logic GP_OUTPUT_THREE_O,
    input wire logic GP_OUTPUT_FOUR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] b5_on_reg; // Cycles buck five has been on
    // Counts enabled cycles of buck five
    always_ff @(posedge SYS_CLK) begin
        b5_on_reg <= (!NRST || !RAIL_EN[4]) ? 32'h0 : b5_on_reg + 32'h1;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_disch_tracks_en: assert property (DISCH_ON == ~RAIL_EN) else $error("discharge not inverse of enable");
    a_lin_reg_only: assert property ($changed(RAIL_EN[8:7]) |-> ($past(WR) && $past(ADDR) == OFS_RAIL_CTRL)
        || ($past(WR, 2) && $past(ADDR, 2) == OFS_RAIL_CTRL)) else $error("lin two/three moved without write");
    a_b6_delay: assert property ($rose(RAIL_EN[5]) |-> b5_on_reg >= MEM_DELAY) else $error("buck six early");
    a_lin1_after_b6: assert property ($rose(RAIL_EN[6]) |-> $past(RAIL_EN[5])) else $error("lin one early");
    a_term_after_b6: assert property ($rose(RAIL_EN[9]) |-> $past(RAIL_EN[5])) else $error("termination early");
    a_b5_after_b2: assert property ($rose(RAIL_EN[4]) |-> $past(RAIL_EN[1])) else $error("buck five early");
    a_b2_volt_pin: assert property ($stable(CTL_IN[5]) [*3] |->
        BUCK_TWO_MV == (CTL_IN[5] ? B2_NORMAL_MV : B2_SLEEP_MV)) else $error("buck two voltage wrong");
    a_b6_volt_pin: assert property ($stable(CTL_IN[1]) [*3] |->
        BUCK_SIX_MV == (CTL_IN[1] ? B6_HIGH_MV : B6_LOW_MV)) else $error("buck six voltage wrong");
    a_term_ilim: assert property (TERM_ILIM == TERM_ILIM_MA) else $error("termination limit wrong");
    a_gpo_open_drain: assert property ({GP_OUTPUT_TWO_O, GP_OUTPUT_THREE_O, GP_OUTPUT_FOUR_O} == 3'h0)
        else $error("open-drain output driven high");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside slot");
    c_term_on: cover property ($rose(RAIL_EN[9]));
    c_chain_down: cover property ($fell(RAIL_EN[5]));
    c_read_data: cover property (RD ##1 RDATA != 32'h0);
endmodule
bind mrps_top mrps_chk #(.MEM_DELAY(MEM_DELAY)) mrps_chk_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CTL_IN(CTL_IN), .RAIL_EN(RAIL_EN), .DISCH_ON(DISCH_ON),
    .BUCK_TWO_MV(BUCK_TWO_MV), .BUCK_SIX_MV(BUCK_SIX_MV), .TERM_ILIM(TERM_ILIM), .GP_OUTPUT_TWO_O(GP_OUTPUT_TWO_O),
    .GP_OUTPUT_THREE_O(GP_OUTPUT_THREE_O), .GP_OUTPUT_FOUR_O(GP_OUTPUT_FOUR_O));
`default_nettype wire

// [sim/mrps_rails.sv]
`default_nettype none
// Far-side rail model: power-good follows enable after a ramp
module mrps_rails #(
    parameter int RAMP = 4
) (
    input wire logic clk,
    input wire logic [11:0] en,
    input wire logic [11:0] kill,
    output logic [11:0] pg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ramp_reg [12]; // Ramp progress per rail
    // Ramp restarts whenever the enable drops
    always_ff @(posedge clk) begin
        for (int i = 0; i < 12; i++) begin
            ramp_reg[i] <= !en[i] ? 4'h0 : (ramp_reg[i] == RAMP[3:0]) ? ramp_reg[i] : ramp_reg[i] + 4'h1;
        end
    end
    // Good once ramped, unless the bench makes the rail collapse
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            pg[i] = en[i] && ramp_reg[i] == RAMP[3:0] && !kill[i];
        end
    end
endmodule
`default_nettype wire

// [sim/mrps_top_tb.sv]
`default_nettype none
// Bench for the rail sequencer
module mrps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mrps_pkg::*;
    localparam int DLY = 20;
    logic SYS_CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [5:0] ctl = 6'h00, CTL_IN;
    logic [11:0] kill = 12'h000, RAIL_PG_IN, RAIL_EN, DISCH_ON;
    logic [23:0] DISCH_SEL;
    logic [11:0] BUCK_TWO_MV, BUCK_THREE_MV, BUCK_SIX_MV, TERM_ILIM;
    logic GP_OUTPUT_ONE, g2o, g2e, g3o, g3e, g4o, g4e, FAULT;
    int fails = 0, compares = 0, cyc = 0, t0 = 0;
    assign CTL_IN = {ctl[5:4], GP_OUTPUT_ONE === 1'b1, ctl[2:0]};
    always #5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) cyc <= cyc + 1;
    mrps_top #(.MEM_DELAY(DLY)) mrps_top_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .CTL_IN(CTL_IN), .RAIL_PG_IN(RAIL_PG_IN), .RAIL_EN(RAIL_EN),
        .DISCH_ON(DISCH_ON), .DISCH_SEL(DISCH_SEL), .BUCK_TWO_MV(BUCK_TWO_MV), .BUCK_THREE_MV(BUCK_THREE_MV),
        .BUCK_SIX_MV(BUCK_SIX_MV), .TERM_ILIM(TERM_ILIM), .GP_OUTPUT_ONE(GP_OUTPUT_ONE), .GP_OUTPUT_TWO_O(g2o),
        .GP_OUTPUT_TWO_OE(g2e), .GP_OUTPUT_THREE_O(g3o), .GP_OUTPUT_THREE_OE(g3e), .GP_OUTPUT_FOUR_O(g4o),
        .GP_OUTPUT_FOUR_OE(g4e), .FAULT(FAULT));
    mrps_rails mrps_rails_inst (.clk(SYS_CLK), .en(RAIL_EN), .kill(kill), .pg(RAIL_PG_IN));
    ////////////////////////////////////////////////////////////
    // Shared helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, e);
    endtask
    // Bounded wait for one rail enable
    task wait_en(input int i);
        int n;
        n = 0;
        while (RAIL_EN[i] !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk({31'h0, RAIL_EN[i]}, 32'h1);
    endtask
    task wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk({19'h0, g2e, DISCH_ON}, 32'h1FFF);
        rd(OFS_SHARED_CTRL, 32'h3);
        rd(OFS_DISCH_ONE, 32'h5555);
        rd(OFS_B3_SLEEP_VOLT, 32'h4B0);
        rd(8'h40, 32'h0);
    endtask
    task t_power_up;
        @(posedge SYS_CLK);
        ctl <= 6'h35;
        wait_en(1);
        chk({20'h0, RAIL_EN & 12'h030}, 32'h0);
        wait_en(4);
        t0 = cyc;
        wait_en(5);
        chk({31'h0, cyc - t0 >= DLY && cyc - t0 <= DLY + 4}, 32'h1);
        chk({31'h0, RAIL_EN[6]}, 32'h0);
        wait_en(6);
        wait_en(9);
        wait_en(11);
        tick(8);
        chk({20'h0, RAIL_EN & 12'h180}, 32'h0);
        chk({29'h0, GP_OUTPUT_ONE, g3e, g4e}, 32'h4);
        rd(OFS_STATUS, 32'h0E7F0E7F);
    endtask
    task t_regs;
        wr(OFS_RAIL_CTRL, 32'h3);
        wr(OFS_SHARED_CTRL, 32'h5);
        wr(OFS_DISCH_ONE, 32'h1234);
        wr(OFS_GPO_CTRL, 32'h1);
        tick(3);
        chk({20'h0, RAIL_EN & 12'h180}, 32'h180);
        chk({19'h0, g2e, DISCH_ON & 12'h180}, 32'h0);
        chk({8'h0, DISCH_SEL}, 32'h951234);
    endtask
    task t_sleep;
        @(posedge SYS_CLK);
        ctl <= 6'h17;
        wr(OFS_B3_SLEEP_VOLT, 32'h44C);
        tick(4);
        chk({8'h0, BUCK_TWO_MV, BUCK_SIX_MV}, 32'h352546);
        chk({20'h0, BUCK_THREE_MV}, 32'h44C);
        ctl <= 6'h35;
        tick(5);
        chk({8'h0, BUCK_TWO_MV, BUCK_SIX_MV}, 32'h3844B0);
    endtask
    task t_fault;
        kill <= 12'h080;
        tick(10);
        chk({31'h0, FAULT}, 32'h0);
        kill <= 12'h280;
        tick(10);
        chk({31'h0, FAULT}, 32'h1);
        kill <= 12'h000;
        tick(4);
        wr(OFS_FAULT, 32'hFFF);
        tick(10);
        chk({31'h0, FAULT}, 32'h0);
    endtask
    task t_power_down;
        ctl <= 6'h31;
        tick(10);
        chk({20'h0, RAIL_EN}, 32'h180);
        chk({20'h0, DISCH_ON}, 32'hE7F);
    endtask
    initial begin
        repeat (20) @(posedge SYS_CLK);
        NRST <= 1'b1;
        tick(4);
        t_reset;
        t_power_up;
        t_regs;
        t_sleep;
        t_fault;
        t_power_down;
        wrap_up;
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        fails++;
        wrap_up;
    end
endmodule
`default_nettype wire
